/* File: common/bcts_pkg.sv */
// Package for the bus clock and timing supervisor: register offsets, field
// positions, reset values and timing constants.
// Assumes a 32-bit AXI4-Lite register port and a single 200 MHz clock.
package bcts_pkg;
  // ==========================================================
  // Register map (byte addresses inside the relocatable window)
  localparam logic [10:0] OFF_WAIT_DIV = 11'h000;
  localparam logic [10:0] OFF_PIRQ_CTL = 11'h004;
  localparam logic [10:0] OFF_PIRQ_FLG = 11'h008;
  localparam logic [10:0] OFF_WDOG_CTL = 11'h00C;
  localparam logic [10:0] OFF_WDOG_SVC = 11'h010;
  localparam logic [10:0] OFF_IRQ_STAT = 11'h014;
  localparam logic [10:0] OFF_IRQ_MASK = 11'h018;
  localparam logic [10:0] OFF_BASE = 11'h01C;
  // ==========================================================
  // Field positions
  localparam int PIRQ_EN_BIT = 7;
  localparam int STOP_WAIT_BIT = 6;
  localparam int STOP_DBG_BIT = 5;
  localparam int BYPASS_BIT = 4;
  localparam int PFLAG_BIT = 7;
  localparam int CLKMON_EN_BIT = 7;
  // Status bits: periodic timeout, watchdog reset, clock-loss reset.
  localparam int ST_PER = 0;
  localparam int ST_WDG = 1;
  localparam int ST_CLK = 2;
  // ==========================================================
  // Service sequence values
  localparam logic [7:0] WDOG_ARM = 8'h55;
  localparam logic [7:0] WDOG_KICK = 8'hAA;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int CLKMON_MAX_NS = 2000;
  localparam int CLKMON_CYC = (CLKMON_MAX_NS * CLK_MHZ) / 1000;
  localparam int PRESCALE_LOG2 = 13;
  localparam int BYPASS_DIV = 4;
  localparam int RST_PULSE_CYC = 16;
  localparam logic [4:0] BASE_RESET = 5'h00;
  // ==========================================================
  // Grouped status of the block
  typedef struct packed {
    logic wait_mode;
    logic debug_mode;
    logic special_mode;
  } bcts_mode_s;
  typedef enum logic [2:0] {
    BCTS_SVC_IDLE = 3'b001,
    BCTS_SVC_ARMED = 3'b010,
    BCTS_SVC_RESET = 3'b100
  } bcts_svc_e;
endpackage

/* File: design/bcts_top.sv */
// Bus clock and timing supervisor: wait-mode slow divider, periodic interrupt,
// two-step watchdog and clock-loss monitor, with an AXI4-Lite register port.
// Assumes mode inputs synchronous to aclk and osc_edge as a sampled clock tick.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module bcts_top #(
  parameter int WDOG_MAX_LOG2 = 23,
  parameter int CLKMON_CYCLES = bcts_pkg::CLKMON_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire bcts_pkg::bcts_mode_s mode,
  input wire logic osc_edge,
  output logic bus_clk_en,
  output logic wait_clk_en,
  output logic system_reset,
  output logic irq
);
  if (WDOG_MAX_LOG2 < 23 || WDOG_MAX_LOG2 > 30 || CLKMON_CYCLES < 2
      || CLKMON_CYCLES > 65535) begin : g_bad_param
    $error("bcts_top: unsupported parameter value");
  end

  // ==========================================================
  // Registers
  logic [2:0] wait_div_q;
  logic pirq_en_q, stop_wait_q, stop_dbg_q, bypass_q;
  logic [2:0] prate_q;
  logic pflag_q;
  logic clkmon_en_q;
  logic [2:0] wrate_q;
  logic stop_wait_lk_q, stop_dbg_lk_q, wrate_lk_q;
  logic [2:0] stat_q, mask_q;
  logic [4:0] base_q;
  bcts_pkg::bcts_svc_e svc_q;

  // ==========================================================
  // AXI4-Lite write path
  logic aw_have_q, w_have_q;
  logic [31:0] aw_addr_q, w_data_q;
  logic [3:0] w_strb_q;
  wire wr_fire = aw_have_q && w_have_q && !bvalid;
  wire in_window = aw_addr_q[15:11] == base_q;
  wire [10:0] wr_off = aw_addr_q[10:0];
  wire [7:0] wb = w_data_q[7:0];
  wire lane0 = w_strb_q[0];
  wire wr_wdiv = wr_fire && in_window && wr_off == bcts_pkg::OFF_WAIT_DIV && lane0;
  wire wr_pctl = wr_fire && in_window && wr_off == bcts_pkg::OFF_PIRQ_CTL && lane0;
  wire wr_pflg = wr_fire && in_window && wr_off == bcts_pkg::OFF_PIRQ_FLG && lane0;
  wire wr_wctl = wr_fire && in_window && wr_off == bcts_pkg::OFF_WDOG_CTL && lane0;
  wire wr_svc = wr_fire && in_window && wr_off == bcts_pkg::OFF_WDOG_SVC && lane0;
  wire wr_mask = wr_fire && in_window && wr_off == bcts_pkg::OFF_IRQ_MASK && lane0;
  wire wr_base = wr_fire && aw_addr_q[10:0] == bcts_pkg::OFF_BASE && in_window && lane0;
  wire wr_known = wr_fire && in_window && (wr_wdiv || wr_pctl || wr_pflg || wr_wctl
                  || wr_svc || wr_mask || wr_base || wr_off == bcts_pkg::OFF_IRQ_STAT);
  // Ready flags are registered inverses of the next holding state, so they leave a flip-flop.
  wire aw_have_d = (awvalid && awready) || (aw_have_q && !wr_fire);
  wire w_have_d = (wvalid && wready) || (w_have_q && !wr_fire);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 32'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      awready <= 1'b1;
      wready <= 1'b1;
    end else begin
      aw_have_q <= aw_have_d;
      awready <= !aw_have_d;
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
      end
      w_have_q <= w_have_d;
      wready <= !w_have_d;
      if (wvalid && wready) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_known ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  wire rd_fire = arvalid && arready;
  wire rd_in = araddr[15:11] == base_q;
  wire [10:0] rd_off = araddr[10:0];
  logic [7:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 8'h00;
    rd_ok = rd_in;
    if (!rd_in) begin
      rd_ok = 1'b0;
    end else if (rd_off == bcts_pkg::OFF_WAIT_DIV) begin
      rd_val = {5'h00, wait_div_q};
    end else if (rd_off == bcts_pkg::OFF_PIRQ_CTL) begin
      rd_val = {pirq_en_q, stop_wait_q, stop_dbg_q, bypass_q, 1'b0, prate_q};
    end else if (rd_off == bcts_pkg::OFF_PIRQ_FLG) begin
      rd_val = {pflag_q, 7'h00};
    end else if (rd_off == bcts_pkg::OFF_WDOG_CTL) begin
      rd_val = {clkmon_en_q, 4'h0, wrate_q};
    end else if (rd_off == bcts_pkg::OFF_WDOG_SVC) begin
      rd_val = 8'h00;
    end else if (rd_off == bcts_pkg::OFF_IRQ_STAT) begin
      rd_val = {5'h00, stat_q};
    end else if (rd_off == bcts_pkg::OFF_IRQ_MASK) begin
      rd_val = {5'h00, mask_q};
    end else if (rd_off == bcts_pkg::OFF_BASE) begin
      rd_val = {3'h0, base_q};
    end else begin
      rd_ok = 1'b0;
    end
  end
  wire rd_stat = rd_fire && rd_ok && rd_off == bcts_pkg::OFF_IRQ_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
      arready <= 1'b1;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      arready <= 1'b0;
      rdata <= {24'h000000, rd_val};
      rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // Control registers with write-once and special-mode protection
  wire sp = mode.special_mode;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_div_q <= 3'h0;
      pirq_en_q <= 1'b0;
      stop_wait_q <= 1'b0;
      stop_dbg_q <= 1'b0;
      bypass_q <= 1'b0;
      prate_q <= 3'h0;
      clkmon_en_q <= 1'b0;
      wrate_q <= 3'h0;
      stop_wait_lk_q <= 1'b0;
      stop_dbg_lk_q <= 1'b0;
      wrate_lk_q <= 1'b0;
      mask_q <= 3'h0;
      base_q <= bcts_pkg::BASE_RESET;
    end else begin
      if (wr_wdiv) begin
        wait_div_q <= wb[2:0];
      end
      if (wr_pctl) begin
        pirq_en_q <= wb[bcts_pkg::PIRQ_EN_BIT];
        prate_q <= wb[2:0];
        if (sp || !stop_wait_lk_q) begin
          stop_wait_q <= wb[bcts_pkg::STOP_WAIT_BIT];
          stop_wait_lk_q <= !sp;
        end
        if (sp || !stop_dbg_lk_q) begin
          stop_dbg_q <= wb[bcts_pkg::STOP_DBG_BIT];
          stop_dbg_lk_q <= !sp;
        end
        if (sp) begin
          bypass_q <= wb[bcts_pkg::BYPASS_BIT];
        end
      end
      if (wr_wctl) begin
        clkmon_en_q <= wb[bcts_pkg::CLKMON_EN_BIT];
        if (sp || !wrate_lk_q) begin
          wrate_q <= wb[2:0];
          wrate_lk_q <= !sp;
        end
      end
      if (wr_mask) begin
        mask_q <= wb[2:0];
      end
      if (wr_base) begin
        base_q <= wb[4:0];
      end
    end
  end

  // ==========================================================
  // Wait-mode slow divider and clock enables
  logic [6:0] slow_cnt_q;
  logic half_q;
  wire slow_on = mode.wait_mode && wait_div_q != 3'h0;
  wire [6:0] slow_lim = 7'((8'h01 << wait_div_q) - 8'h01);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_cnt_q <= 7'h00;
      half_q <= 1'b0;
      bus_clk_en <= 1'b0;
      wait_clk_en <= 1'b0;
    end else begin
      half_q <= !half_q;
      wait_clk_en <= half_q;
      if (!slow_on || slow_cnt_q >= slow_lim) begin
        slow_cnt_q <= 7'h00;
      end else begin
        slow_cnt_q <= slow_cnt_q + 7'h01;
      end
      bus_clk_en <= !slow_on || slow_cnt_q == 7'h00;
    end
  end

  // ==========================================================
  // Prescale chain on the E clock for the periodic interrupt; the watchdog counts on its own wcnt_q
  logic [WDOG_MAX_LOG2-1:0] chain_q;
  wire timers_run = !(stop_wait_q && mode.wait_mode) && !(stop_dbg_q && mode.debug_mode);
  // Bypass keeps two stages of the prescaler and skips the rest.
  wire [4:0] pre_sh = bypass_q ? 5'($clog2(bcts_pkg::BYPASS_DIV))
                               : 5'(bcts_pkg::PRESCALE_LOG2);
  function automatic logic tick_at(input logic [WDOG_MAX_LOG2-1:0] c, input logic [4:0] lg);
    logic [WDOG_MAX_LOG2-1:0] m;
    m = (WDOG_MAX_LOG2'(1) << lg) - WDOG_MAX_LOG2'(1);
    tick_at = (c & m) == m;
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_q <= '0;
    end else if (timers_run) begin
      chain_q <= chain_q + WDOG_MAX_LOG2'(1);
    end
  end

  // ==========================================================
  // Periodic interrupt
  wire [4:0] p_lg = 5'(pre_sh + 5'(prate_q) - 5'h01);
  wire p_tick = timers_run && prate_q != 3'h0 && tick_at(chain_q, p_lg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pflag_q <= 1'b0;
    end else if (p_tick) begin
      pflag_q <= 1'b1;
    end else if (wr_pflg && wb[bcts_pkg::PFLAG_BIT]) begin
      pflag_q <= 1'b0;
    end
  end

  // ==========================================================
  // Watchdog
  logic [4:0] w_ext;
  always_comb begin
    case (wrate_q)
      3'd1: w_ext = 5'd0;
      3'd2: w_ext = 5'd2;
      3'd3: w_ext = 5'd4;
      3'd4: w_ext = 5'd6;
      3'd5: w_ext = 5'd8;
      3'd6: w_ext = 5'd9;
      default: w_ext = 5'd10;
    endcase
  end
  logic [WDOG_MAX_LOG2-1:0] wcnt_q;
  wire w_on = wrate_q != 3'h0;
  wire [4:0] w_lg = 5'(pre_sh + w_ext);
  wire w_tmo = w_on && timers_run && tick_at(wcnt_q, w_lg);
  wire svc_bad = wr_svc && wb != bcts_pkg::WDOG_ARM && wb != bcts_pkg::WDOG_KICK;
  wire svc_kick = wr_svc && wb == bcts_pkg::WDOG_KICK && svc_q == bcts_pkg::BCTS_SVC_ARMED;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      svc_q <= bcts_pkg::BCTS_SVC_IDLE;
      wcnt_q <= '0;
    end else begin
      if (wr_svc) begin
        case (svc_q)
          bcts_pkg::BCTS_SVC_IDLE:
            svc_q <= wb == bcts_pkg::WDOG_ARM ? bcts_pkg::BCTS_SVC_ARMED : svc_q;
          bcts_pkg::BCTS_SVC_ARMED:
            svc_q <= svc_kick ? bcts_pkg::BCTS_SVC_RESET :
                     (wb == bcts_pkg::WDOG_ARM ? svc_q : bcts_pkg::BCTS_SVC_IDLE);
          default:
            svc_q <= wb == bcts_pkg::WDOG_ARM ? bcts_pkg::BCTS_SVC_ARMED
                                              : bcts_pkg::BCTS_SVC_IDLE;
        endcase
      end
      if (svc_kick || !w_on) begin
        wcnt_q <= '0;
      end else if (timers_run) begin
        wcnt_q <= wcnt_q + WDOG_MAX_LOG2'(1);
      end
    end
  end

  // ==========================================================
  // Clock-loss monitor; counts aclk cycles since the last oscillator tick.
  // Counting on aclk keeps it tied to the oscillator, not the slowed bus.
  logic [15:0] mon_q;
  wire mon_trip = clkmon_en_q && mon_q >= 16'(CLKMON_CYCLES);
  always_ff @(posedge aclk) begin
    if (!aresetn || osc_edge || !clkmon_en_q) begin
      mon_q <= 16'h0000;
    end else if (mon_q != 16'hFFFF) begin
      mon_q <= mon_q + 16'h0001;
    end
  end

  // ==========================================================
  // Reset request, status and interrupt
  logic [4:0] rst_cnt_q;
  wire [2:0] ev = {mon_trip, w_tmo || svc_bad, p_tick};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_q <= 5'h00;
      system_reset <= 1'b0;
      stat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (ev[bcts_pkg::ST_WDG] || ev[bcts_pkg::ST_CLK]) begin
        rst_cnt_q <= 5'(bcts_pkg::RST_PULSE_CYC);
      end else if (rst_cnt_q != 5'h00) begin
        rst_cnt_q <= rst_cnt_q - 5'h01;
      end
      system_reset <= ev[bcts_pkg::ST_WDG] || ev[bcts_pkg::ST_CLK] || rst_cnt_q > 5'h01;
      stat_q <= ev | (rd_stat ? 3'h0 : stat_q);
      irq <= |(stat_q & mask_q) || (pirq_en_q && pflag_q);
    end
  end
endmodule

/* File: sim/bcts_asserts.sv */
// Checker for bcts_top: bus handshakes, clock enables and the reset pulse.
// Assumes it is bound to bcts_top and sees only the ports of that module.
`timescale 1ns/10ps
module bcts_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire bcts_pkg::bcts_mode_s mode,
  input wire logic bus_clk_en,
  input wire logic wait_clk_en,
  input wire logic system_reset
);
  // ==========================================================
  // Helper: cycles since the last bus clock enable
  logic [7:0] gap_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) gap_q <= 8'h00;
    else if (bus_clk_en) gap_q <= 8'h00;
    else gap_q <= gap_q + 8'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Assertions
  div_bound_a: assert property (gap_q < 8'h80)
    else $error("bus clock enable gap longer than 128 cycles");
  bus_full_a: assert property (!mode.wait_mode [*3] |-> bus_clk_en)
    else $error("bus clock enable missing outside wait mode");
  wait_toggle_a: assert property ($past(aresetn, 2) |-> wait_clk_en != $past(wait_clk_en))
    else $error("wait clock enable did not toggle");
  rst_pulse_a: assert property ($rose(system_reset) |-> system_reset [*8])
    else $error("system reset pulse too short");
  write_lat_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  read_lat_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rresp, rdata}))
    else $error("read data dropped early");
  resp_once_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated after it was taken");
endmodule
bind bcts_top bcts_asserts u_bcts_asserts (.*);

/* File: sim/testbench.sv */
// Self-checking bench for bcts_top: AXI4-Lite master, mode and oscillator drive.
// Assumes a single 200 MHz clock and a clock-loss window cut to 8 cycles.
`timescale 1ns/10ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, osc_edge = 1'b0, osc_run = 1'b1;
  logic bready = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bus_clk_en, wait_clk_en, system_reset, irq;
  logic [1:0] bresp, rresp, osc_cnt = 2'h0;
  bcts_pkg::bcts_mode_s mode = '0;
  logic [33:0] exp_q[$];
  int n_fail = 0, n_compared = 0, n_rst = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  // Response ready is raised a random 0 to 2 cycles late, so responses must stand.
  bcts_top #(.CLKMON_CYCLES(8)) u_bcts_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .mode(mode), .osc_edge(osc_edge), .bus_clk_en(bus_clk_en),
    .wait_clk_en(wait_clk_en), .system_reset(system_reset), .irq(irq));
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    osc_cnt <= osc_cnt + 2'h1;
    osc_edge <= osc_run && osc_cnt == 2'h0;
    if (system_reset === 1'b1) n_rst <= n_rst + 1;
    if (bvalid === 1'b1 && bready) chk({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid === 1'b1 && rready) chk({rresp, rdata}, exp_q.pop_front());
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    repeat ($urandom_range(0, 2)) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    exp_q.push_back({r, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat ($urandom_range(0, 2)) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic count256(output int c, output int w);
    c = 0;
    w = 0;
    repeat (256) begin
      @(posedge aclk);
      if (bus_clk_en === 1'b1) c++;
      if (wait_clk_en === 1'b1) w++;
    end
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    int c, w, r0, bad;
    void'($urandom(59));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(32'(4 * i), 8'h00);
    rd(32'h20, 8'h00, 2'h2);
    wr(32'h1C, 8'h01);
    rd(32'h804, 8'h00);
    rd(32'h004, 8'h00, 2'h2);
    wr(32'h81C, 8'h00);
    wr(32'h04, 8'h70);
    rd(32'h04, 8'h60);
    wr(32'h04, 8'h00);
    rd(32'h04, 8'h60);
    mode.wait_mode <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(32'h00, 8'(s));
      repeat (140) @(posedge aclk);
      count256(c, w);
      chk(34'(c), 34'(256 >> s));
      chk(34'(w), 34'h80);
    end
    mode.wait_mode <= 1'b0;
    repeat (4) @(posedge aclk);
    count256(c, w);
    chk(34'(c), 34'h100);
    // Bypass gives short timer periods: periodic 2^(1+rate), watchdog 2^(2+ext).
    mode.special_mode <= 1'b1;
    wr(32'h04, 8'h97);
    repeat (300) @(posedge aclk);
    chk(34'(irq), 34'h1);
    rd(32'h08, 8'h80);
    wr(32'h04, 8'h17);
    repeat (3) @(posedge aclk);
    chk(34'(irq), 34'h0);
    wr(32'h04, 8'h10);
    wr(32'h08, 8'h80);
    rd(32'h08, 8'h00);
    repeat (600) @(posedge aclk);
    rd(32'h08, 8'h00);
    rd(32'h14, 8'h01);
    rd(32'h14, 8'h00);
    // Debug halt: fast periodic rate, yet no timeout may reach the status register.
    mode.debug_mode <= 1'b1;
    wr(32'h04, 8'h37);
    repeat (600) @(posedge aclk);
    rd(32'h14, 8'h00);
    mode.debug_mode <= 1'b0;
    wr(32'h18, 8'h01);
    wr(32'h04, 8'h17);
    c = 0;
    while (irq !== 1'b1 && c < 400) begin
      @(posedge aclk);
      c++;
    end
    chk(34'(irq), 34'h1);
    wr(32'h04, 8'h10);
    rd(32'h14, 8'h01);
    repeat (2) @(posedge aclk);
    chk(34'(irq), 34'h0);
    wr(32'h18, 8'h00);
    wr(32'h0C, 8'h05);
    r0 = n_rst;
    repeat (5) begin
      repeat ($urandom_range(150, 300)) @(posedge aclk);
      wr(32'h10, 8'h55);
      wr(32'h10, 8'hAA);
    end
    chk(34'(n_rst - r0), 34'h0);
    repeat (3) begin
      repeat (300) @(posedge aclk);
      wr(32'h10, 8'hAA);
    end
    repeat (80) @(posedge aclk);
    chk(34'(n_rst - r0), 34'h0);
    repeat (60) @(posedge aclk);
    chk(34'(n_rst > r0), 34'h1);
    wr(32'h0C, 8'h00);
    rd(32'h14, 8'h02);
    wr(32'h0C, 8'h07);
    wr(32'h10, 8'h55);
    bad = $urandom_range(0, 255);
    if (bad == 32'h55 || bad == 32'hAA) bad = 1;
    r0 = n_rst;
    wr(32'h10, 8'(bad));
    repeat (3) @(posedge aclk);
    chk(34'(n_rst > r0), 34'h1);
    wr(32'h0C, 8'h80);
    repeat (100) @(posedge aclk);
    r0 = n_rst;
    repeat (100) @(posedge aclk);
    chk(34'(n_rst - r0), 34'h0);
    osc_run <= 1'b0;
    repeat (30) @(posedge aclk);
    chk(34'(n_rst > r0), 34'h1);
    wr(32'h0C, 8'h00);
    rd(32'h14, 8'h06);
    repeat (20) @(posedge aclk);
    report_and_stop();
  end
endmodule
